//--- src/prom_pkg.sv
// Types shared by the serial configuration memory reader.
// Assumes nothing of its surroundings beyond a SystemVerilog compiler.
package prom_pkg;

	// Pin inputs that travel together through the synchroniser
	typedef struct packed
	{
		logic shiftClk;
		logic oeN;
		logic ceN;
	} pins_t;

	// Read sequence: counters cleared, streaming, whole memory read
	typedef enum logic [2:0]
	{
		ST_CLEAR = 3'b001,
		ST_RUN   = 3'b010,
		ST_DONE  = 3'b100
	} read_state_t;

endpackage : prom_pkg

//--- src/prom_regs.svh
// Constants for the serial configuration memory reader.
// Assumes inclusion by bare name; holds definitions only.
`ifndef PROM_REGS_SVH
`define PROM_REGS_SVH

// Stored bits in the array
`define PROM_BITS      36288
// Bits fetched from the array per word
`define PROM_WORD_W    8
// Words held in the prefetch FIFO
`define PROM_FIFO_DEPTH 8
// Synchroniser stages on pin inputs
`define PROM_SYNC_STAGES 2

`endif

//--- src/serial_config_memory.sv
// Read side of the one-time-programmable serial configuration memory,
// with its prefetch FIFO.
// Assumes pins arrive asynchronously and the shift clock is far slower
// than clk_sys; the bench resolves the three-state data wire.
`timescale 1ns/1ps
`include "prom_regs.svh"

// ==========================================================================
// Prefetch FIFO
// ==========================================================================
module prom_fifo #(
	parameter int WIDTH = `PROM_WORD_W,
	parameter int DEPTH = `PROM_FIFO_DEPTH
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	input  wire logic             flush,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wrPtr;
	logic [PW-1:0]    rdPtr;
	logic [PW:0]      count;
	wire              doPush;
	wire              doPop;

	// Pointer step that wraps at the depth, not at a power of two
	function automatic logic [PW-1:0] ptrNext(input logic [PW-1:0] p);
		ptrNext = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction : ptrNext

	// Honest full and empty straight from the occupancy count
	assign inReady  = (count != (PW+1)'(DEPTH)) && !flush;
	assign outValid = (count != '0) && !flush;
	assign outData  = store[rdPtr];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	// Storage has no reset; only the pointers matter
	always_ff @(posedge clk_sys)
	begin
		if (doPush)
			store[wrPtr] <= inData;
	end

	// Pointers and count; flush empties at once
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else if (flush) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			wrPtr <= doPush ? ptrNext(wrPtr) : wrPtr;
			rdPtr <= doPop ? ptrNext(rdPtr) : rdPtr;
			count <= (PW+1)'(count + doPush - doPop);
		end
	end
endmodule : prom_fifo

// ==========================================================================
// Memory reader
// ==========================================================================
module serial_config_memory #(
	parameter int BITS   = `PROM_BITS,
	parameter int WORD_W = `PROM_WORD_W,
	parameter int DEPTH  = `PROM_FIFO_DEPTH
) (
	input  wire logic                             clk_sys,
	input  wire logic                             rst_b,
	input  wire logic                             config_shift_clock,
	input  wire logic                             chipEnableN,
	input  wire logic                             outputEnableN,
	input  wire logic                             progWrite,
	input  wire logic [$clog2(BITS/WORD_W)-1:0]   progAddr,
	input  wire logic [WORD_W-1:0]                progWord,
	output logic                                  serialData,
	output logic                                  serialDataOe,
	output logic                                  cascade_select_out_n,
	output logic                                  lowPower
);
	localparam int WORDS = BITS / WORD_W;
	localparam int AW    = $clog2(WORDS);
	localparam int BW    = $clog2(WORD_W);

	// ======================================================================
	// Pin synchronisers
	// ======================================================================
	prom_pkg::pins_t pinMeta;
	prom_pkg::pins_t pins;
	logic            shiftLast;

	// Two flops before any logic; the first is read by the second only
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b) begin
			pinMeta   <= '{shiftClk: 1'b0, oeN: 1'b1, ceN: 1'b1};
			pins      <= '{shiftClk: 1'b0, oeN: 1'b1, ceN: 1'b1};
			shiftLast <= 1'b0;
		end else begin
			pinMeta   <= '{shiftClk: config_shift_clock,
				oeN: outputEnableN, ceN: chipEnableN};
			pins      <= pinMeta;
			shiftLast <= pins.shiftClk;
		end
	end

	// ======================================================================
	// Decoding of pin levels
	// ======================================================================
	wire clearReq  = pins.oeN;
	wire selected  = !pins.ceN;
	wire shiftEdge = pins.shiftClk && !shiftLast;
	wire countEdge = shiftEdge && selected && !clearReq;
	wire bothLow   = !pins.ceN && !pins.oeN;

	// Position of the last stored bit
	function automatic logic isLast(input logic [AW-1:0] a,
		input logic [BW-1:0] b);
		isLast = (a == AW'(WORDS - 1)) && (b == BW'(WORD_W - 1));
	endfunction : isLast

	// ======================================================================
	// Array and fetch side
	// ======================================================================
	logic [WORD_W-1:0] mem [WORDS];
	logic [AW-1:0]     fetchAddr;
	logic              fetchPend;
	logic              fetchEnd;
	logic [WORD_W-1:0] fetchWord;
	logic              fifoInReady;
	logic              fifoOutValid;
	logic [WORD_W-1:0] fifoOutData;
	wire               fetchGo;
	wire               fetchMore;

	// One read in flight at a time, so a free slot is always there for it
	assign fetchMore = !fetchEnd;
	assign fetchGo   = !clearReq && !fetchPend && fifoInReady && fetchMore;

	// Contents arrive over the programming port; reads are registered
	always_ff @(posedge clk_sys)
	begin
		if (progWrite)
			mem[progAddr] <= progWord;
		fetchWord <= mem[fetchAddr];
	end

	// Fetch address restarts with every counter clear; it parks on the
	// last word so a power-of-two array never wraps and refetches word 0
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b) begin
			fetchAddr <= '0;
			fetchPend <= 1'b0;
			fetchEnd  <= 1'b0;
		end else if (clearReq) begin
			fetchAddr <= '0;
			fetchPend <= 1'b0;
			fetchEnd  <= 1'b0;
		end else begin
			fetchPend <= fetchGo;
			if (fetchGo && fetchAddr == AW'(WORDS - 1))
				fetchEnd <= 1'b1;
			else if (fetchGo)
				fetchAddr <= AW'(fetchAddr + 1'b1);
		end
	end

	// ======================================================================
	// Read state and counters
	// ======================================================================
	prom_pkg::read_state_t state;
	prom_pkg::read_state_t next_state;
	logic [AW-1:0]         posAddr;
	logic [BW-1:0]         posBit;
	logic [WORD_W-1:0]     curWord;
	logic                  curValid;
	wire                   atLast;
	wire                   takeWord;
	wire                   curBit;

	assign atLast   = isLast(posAddr, posBit);
	assign curBit   = curWord[posBit];
	assign takeWord = !curValid && fifoOutValid && !clearReq;

	prom_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_sys  (clk_sys),
		.rst_b    (rst_b),
		.flush    (clearReq),
		.inValid  (fetchPend && !clearReq),
		.inReady  (fifoInReady),
		.inData   (fetchWord),
		.outValid (fifoOutValid),
		.outReady (takeWord),
		.outData  (fifoOutData)
	);

	// Sequence: clear holds while output enable is high, done after last edge
	always_comb
	begin
		next_state = state;
		case (state)
			prom_pkg::ST_CLEAR:
				next_state = prom_pkg::ST_RUN;
			prom_pkg::ST_RUN:
				if (countEdge && atLast)
					next_state = prom_pkg::ST_DONE;
			prom_pkg::ST_DONE:
				next_state = prom_pkg::ST_DONE;
			default:
				next_state = prom_pkg::ST_CLEAR;
		endcase
		if (clearReq)
			next_state = prom_pkg::ST_CLEAR;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			state <= prom_pkg::ST_CLEAR;
		else
			state <= next_state;
	end

	// Counters step per counted edge in ST_RUN; frozen while chip enable is high and output enable is low
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b) begin
			posAddr <= '0;
			posBit  <= '0;
		end else if (clearReq) begin
			posAddr <= '0;
			posBit  <= '0;
		end else if (countEdge && state == prom_pkg::ST_RUN) begin
			posBit <= BW'(posBit + 1'b1);
			if (posBit == BW'(WORD_W - 1))
				posAddr <= AW'(posAddr + 1'b1);
		end
	end

	// Current word from the FIFO; dropped when its last bit goes by
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b) begin
			curWord  <= '0;
			curValid <= 1'b0;
		end else if (clearReq) begin
			curValid <= 1'b0;
		end else if (takeWord) begin
			curWord  <= fifoOutData;
			curValid <= 1'b1;
		end else if (countEdge && posBit == BW'(WORD_W - 1)) begin
			curValid <= 1'b0;
		end
	end

	// ======================================================================
	// Pin outputs
	// ======================================================================
	wire next_dataOe = bothLow && state != prom_pkg::ST_DONE;
	wire next_ceoN   = !(bothLow && state == prom_pkg::ST_DONE);

	// All outputs registered; LSB of each word leaves first
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b) begin
			serialData           <= 1'b0;
			serialDataOe         <= 1'b0;
			cascade_select_out_n <= 1'b1;
			lowPower             <= 1'b1;
		end else begin
			serialData           <= curBit;
			serialDataOe         <= next_dataOe;
			cascade_select_out_n <= next_ceoN;
			lowPower             <= pins.ceN;
		end
	end

	// ======================================================================
	// Checks
	// ======================================================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_lastShift;
		countEdge && atLast && state == prom_pkg::ST_RUN;
	endsequence

	sequence s_stayEnabled;
		bothLow [*2];
	endsequence

	a_oe_clears: assert property (clearReq |=>
		posAddr == '0 && posBit == '0)
		else $error("counters not cleared by output enable");

	a_ce_freezes: assert property (pins.ceN && !clearReq |=>
		$stable(posAddr) && $stable(posBit))
		else $error("counters moved while deselected");

	a_drive_cond: assert property (serialDataOe |->
		$past(bothLow))
		else $error("data driven without both enables low");

	a_shift_step: assert property (
		countEdge && state == prom_pkg::ST_RUN && !atLast
		&& posBit != BW'(WORD_W - 1)
		|=> posBit == BW'($past(posBit) + 1'b1) && $stable(posAddr))
		else $error("bit counter did not step by one");

	a_low_power: assert property (pins.ceN |=>
		!serialDataOe && lowPower)
		else $error("data driven in low power");

	a_ceo_last: assert property (s_lastShift ##0 s_stayEnabled
		|=> !cascade_select_out_n && !serialDataOe)
		else $error("cascade output late after last bit");

	a_ceo_high: assert property (state != prom_pkg::ST_DONE
		|=> cascade_select_out_n)
		else $error("cascade low before memory read through");

	a_release_last: assert property (state == prom_pkg::ST_DONE
		|=> !serialDataOe)
		else $error("data still driven after last bit");

	a_data_bit: assert property (curValid && !clearReq
		|=> serialData == $past(curBit))
		else $error("output bit differs from stored bit");

	a_word_order: assert property (curValid |->
		curWord == mem[posAddr])
		else $error("current word is not the stored word at its address");

endmodule : serial_config_memory

//--- test/gate_array_model.sv
// Gate array configuration side in master serial loading, behavioural.
// Assumes the bench resolves the data wire and drives both enables.
`timescale 1ns/1ps

// ==========================================================================
// Gate array model
// ==========================================================================
module gate_array_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        go,
	input  wire logic [15:0] edgeCount,
	input  wire logic        dataLine,
	output logic             config_shift_clock,
	output logic             bitValid,
	output logic             bitValue,
	output logic             busy
);
	logic [3:0]  phase;
	logic [15:0] remain;

	// Mode bits all held low, so this is a master serial load; the clock
	// runs only while loading and stands low between loads
	always @(negedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			config_shift_clock <= 1'b0;
			bitValid           <= 1'b0;
			bitValue           <= 1'b0;
			busy               <= 1'b0;
			phase              <= 4'h0;
			remain             <= 16'h0000;
		end
		else
		begin
			bitValid <= 1'b0;
			if (go && !busy)
			begin
				busy   <= 1'b1;
				remain <= edgeCount;
				phase  <= 4'h0;
			end
			else if (busy)
			begin
				phase <= phase + 4'h1;
				// Sample on the rising edge, before the memory steps on
				if (phase == 4'h7)
				begin
					config_shift_clock <= 1'b1;
					bitValid           <= 1'b1;
					bitValue           <= dataLine;
				end
				if (phase == 4'hF)
				begin
					config_shift_clock <= 1'b0;
					remain             <= remain - 16'h0001;
					busy               <= (remain != 16'h0001);
				end
			end
		end
	end

endmodule : gate_array_model

//--- test/tb_serial_config_memory.sv
// Self-checking bench for the serial configuration memory reader.
// Assumes the gate array model beside it; memory shortened to 64 bits.
`timescale 1ns/1ps

// ==========================================================================
// Bench top
// ==========================================================================
module tb_serial_config_memory;
	localparam int BITS = 64;
	logic        clk_sys       = 1'b0;
	logic        rst_b         = 1'b0;
	logic        chipEnableN   = 1'b1;
	logic        outputEnableN = 1'b1;
	logic        progWrite     = 1'b0;
	logic [2:0]  progAddr      = 3'h0;
	logic [7:0]  progWord      = 8'h00;
	logic        go            = 1'b0;
	logic [15:0] edgeCount     = 16'h0000;
	logic        config_shift_clock, bitValid, bitValue, busy;
	logic        serialData, serialDataOe, cascade_select_out_n, lowPower;
	wire         dataLine;
	logic [7:0]  memWords [8];
	logic        expQ [$];
	int          miscompares   = 0;
	int          cmp_count     = 0;
	int          cycles        = 0;

	// Data wire has a pull-up, so a released line reads high
	assign dataLine = serialDataOe ? serialData : 1'b1;

	always #5 clk_sys = ~clk_sys;

	serial_config_memory #(.BITS(BITS), .WORD_W(8), .DEPTH(8))
		i_serial_config_memory (
		.clk_sys(clk_sys), .rst_b(rst_b),
		.config_shift_clock(config_shift_clock),
		.chipEnableN(chipEnableN), .outputEnableN(outputEnableN),
		.progWrite(progWrite), .progAddr(progAddr), .progWord(progWord),
		.serialData(serialData), .serialDataOe(serialDataOe),
		.cascade_select_out_n(cascade_select_out_n), .lowPower(lowPower));

	gate_array_model i_gate_array_model (
		.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .edgeCount(edgeCount),
		.dataLine(dataLine), .config_shift_clock(config_shift_clock),
		.bitValid(bitValid), .bitValue(bitValue), .busy(busy));

	task automatic check_lvl(input logic got, input logic exp, input string s);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t level %s got %b", $time, s, got);
		end
	endtask : check_lvl

	task automatic cmp_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t stream bit got %b want %b", $time, got, exp);
		end
	endtask : cmp_bit

	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	// Enables are driven as the load line would; then let them settle
	task automatic pins(input logic ce, input logic oe, input int n);
		chipEnableN   <= ce;
		outputEnableN <= oe;
		repeat (n) @(negedge clk_sys);
	endtask : pins

	// Note expected bits, then let the model clock them out
	task automatic read_bits(input int from, input int n, input bit floating);
		for (int i = 0; i < n; i++)
			expQ.push_back(floating ? 1'b1 : memWords[(from+i)/8][(from+i)%8]);
		edgeCount <= n[15:0];
		go        <= 1'b1;
		@(negedge clk_sys);
		go <= 1'b0;
		@(negedge clk_sys);
		for (int i = 0; i < 4000 && (busy || expQ.size() != 0); i++)
			@(negedge clk_sys);
		// Notes left over mean bits never arrived; count them as a miss
		check_lvl(expQ.size() == 0, 1'b1, "bits left");
		expQ.delete();
	endtask : read_bits

	// Each sampled bit takes the oldest note; a bit with no note is wrong
	always @(posedge clk_sys)
	begin
		if (bitValid === 1'b1)
		begin
			if (expQ.size() == 0)
				cmp_bit(bitValue, ~bitValue);
			else
				cmp_bit(bitValue, expQ.pop_front());
		end
	end

	// Hang guard: about three times the expected run
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end

	initial
	begin
		void'($urandom(32'h74B68678));
		repeat (5) @(negedge clk_sys);
		check_lvl(serialDataOe, 1'b0, "oe rst");
		check_lvl(cascade_select_out_n, 1'b1, "cas rst");
		rst_b <= 1'b1;
		for (int w = 0; w < BITS/8; w++)
		begin
			memWords[w] = 8'($urandom);
			progAddr  <= w[2:0];
			progWord  <= memWords[w];
			progWrite <= 1'b1;
			@(negedge clk_sys);
		end
		progWrite <= 1'b0;
		$display("test reset and load done");
		pins(1'b0, 1'b0, 10);
		check_lvl(serialDataOe, 1'b1, "oe on");
		check_lvl(lowPower, 1'b0, "awake");
		read_bits(0, BITS, 1'b0);
		repeat (8) @(negedge clk_sys);
		check_lvl(cascade_select_out_n, 1'b0, "cas end");
		check_lvl(serialDataOe, 1'b0, "oe end");
		$display("test full read done");
		pins(1'b1, 1'b0, 6);
		check_lvl(cascade_select_out_n, 1'b1, "cas ce");
		check_lvl(lowPower, 1'b1, "sleep");
		check_lvl(serialDataOe, 1'b0, "oe sleep");
		pins(1'b0, 1'b0, 6);
		check_lvl(cascade_select_out_n, 1'b0, "cas back");
		pins(1'b0, 1'b1, 6);
		check_lvl(cascade_select_out_n, 1'b1, "cas oe");
		check_lvl(serialDataOe, 1'b0, "oe off");
		pins(1'b0, 1'b0, 10);
		check_lvl(cascade_select_out_n, 1'b1, "cas held");
		read_bits(0, 20, 1'b0);
		$display("test cascade and clear done");
		pins(1'b1, 1'b0, 6);
		read_bits(0, 5, 1'b1);
		pins(1'b0, 1'b0, 10);
		read_bits(20, 24, 1'b0);
		$display("test freeze done");
		pins(1'b1, 1'b1, 6);
		pins(1'b1, 1'b0, 6);
		pins(1'b0, 1'b0, 10);
		read_bits(0, 8, 1'b0);
		check_lvl(cascade_select_out_n, 1'b1, "cas part");
		read_bits(8, BITS-8, 1'b0);
		repeat (8) @(negedge clk_sys);
		check_lvl(cascade_select_out_n, 1'b0, "cas reread");
		$display("test standby clear done");
		tally_and_finish();
	end

endmodule : tb_serial_config_memory
